//--- common/pps_fifo_if.sv
// interface carrying the valid/ready stream in and out of the fifo
`timescale 1ns/1ps
interface pps_fifo_if #(parameter int W = 8) ();
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

//--- common/pps_pkg.sv
// package with register map, field positions and reset values of the port buffer status block
package pps_pkg;
  localparam int ADDR_W = 4;
  localparam int NBUF   = 4;

  // word offsets on the register bus
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_IN_DATA = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_OUT_DATA = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_FIFO_LVL = 4'h3;

  // status register field positions
  localparam int BIT_ALL_IN_FULL   = 15;
  localparam int BIT_IN_OVERFLOW   = 14;
  localparam int BIT_IN_FULL_LO    = 8;
  localparam int BIT_ALL_OUT_EMPTY = 7;
  localparam int BIT_OUT_UNDERFLOW = 6;
  localparam int BIT_OUT_EMPTY_LO  = 0;

  // selected buffer index field of the index/level register
  localparam int IDX_LO            = 8;

  // reset values of the per-buffer flags
  localparam logic [NBUF-1:0] RST_IN_FULL   = 4'h0;
  localparam logic [NBUF-1:0] RST_OUT_EMPTY = 4'hf;

  // answer to an unmapped read
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

//--- verif/pps_host_model.sv
// behavioural host driving the byte side of the parallel port
`timescale 1ns/1ps
module pps_host_model (
  input  wire logic       ref_clk,
  input  wire logic       host_stall_n,
  input  wire logic       host_rvalid,
  input  wire logic [7:0] host_rdata,
  output logic            host_wr,
  output logic            host_rd,
  output logic [1:0]      host_addr,
  output logic [7:0]      host_wdata
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 2'h0;
    host_wdata = 8'h00;
  end
  // a stalled host skips that byte rather than waiting
  task automatic put(input logic [1:0] idx, input logic [7:0] b, input int n);
    host_addr <= idx;
    for (int i = 0; i < n; i++) begin
      host_wr <= host_stall_n;
      host_wdata <= b + i[7:0];
      @(posedge ref_clk);
    end
    host_wr <= 1'b0;
    host_wdata <= ~host_wdata;
    @(posedge ref_clk);
  endtask
  task automatic get(input logic [1:0] idx, output logic [7:0] b);
    host_rd <= 1'b1;
    host_addr <= idx;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    @(posedge ref_clk);
    b = (host_rvalid === 1'b1) ? host_rdata : 8'hxx;
  endtask
endmodule

//--- verif/pps_port_status_props.sv
// checker of the status word seen on the register bus of the port status block
`timescale 1ns/1ps
module pps_port_status_props (
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire logic [pps_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic                       host_wr
);
  logic        st_rd, st_wr, ovf_r, unf_r, hw_r, ow_r;
  logic [31:0] d;
  assign st_rd = avs_read && !avs_waitrequest && avs_address == pps_pkg::OFF_STATUS;
  assign st_wr = avs_write && !avs_waitrequest && avs_address == pps_pkg::OFF_STATUS;
  assign d = avs_readdata;
  // ****
  // sticky flags as last read; only a write of zero may drop them
  // ****
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else if (st_rd) begin
      ovf_r <= d[14];
      unf_r <= d[6];
    end else if (st_wr) begin
      ovf_r <= ovf_r & avs_writedata[14];
      unf_r <= unf_r & avs_writedata[6];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_r <= 1'b0;
      ow_r <= 1'b0;
    end else begin
      hw_r <= hw_r | host_wr;
      ow_r <= ow_r | (avs_write && avs_address == pps_pkg::OFF_OUT_DATA);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ovf; st_rd && ovf_r |-> d[14]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag lost");
  property p_in_idle; st_rd && !hw_r |-> d[11:8] == 4'h0; endproperty
  a_in_idle: assert property (p_in_idle) else $error("input full without data");
  property p_some_empty; st_rd && d[11:8] != 4'hf |-> !d[15]; endproperty
  a_some_empty: assert property (p_some_empty) else $error("all full too early");
  property p_out_all; st_rd |-> d[7] == &d[3:0]; endproperty
  a_out_all: assert property (p_out_all) else $error("all empty wrong");
  property p_unf; st_rd && unf_r |-> d[6]; endproperty
  a_unf: assert property (p_unf) else $error("underflow flag lost");
  property p_out_idle; st_rd && !ow_r |-> d[3:0] == 4'hf; endproperty
  a_out_idle: assert property (p_out_idle) else $error("output empty wrong");
  property p_rsvd; st_rd |-> d[31:16] == 16'h0 && d[13:12] == 2'h0 && d[5:4] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_all_full; st_rd && d[11:8] == 4'hf |-> d[15]; endproperty
  a_all_full: assert property (p_all_full) else $error("all full missing");
  c_full: cover property (st_rd && d[15]);
  c_ovf: cover property (st_rd && d[14]);
  c_unf: cover property (st_rd && d[6]);
endmodule
bind pps_port_status pps_port_status_props i_props (.ref_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .host_wr);

//--- verif/pps_port_status_tb.sv
// bench of the port status block against a behavioural host
`timescale 1ns/1ps
module pps_port_status_tb;
  typedef struct {int op; int a; logic [7:0] dat; logic [15:0] st;} pps_row_t;
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        host_wr, host_rd, host_rvalid, host_stall_n;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [1:0]  host_addr;
  logic [7:0]  host_wdata, host_rdata, hd;
  int          n_fail, checked, cyc;
  // ops: 0 host write, 1 sw read in, 2 sw write out, 3 host read, 4 status write
  pps_row_t    rows [12] = '{
    '{0, 0, 8'h00, 16'h018f}, '{0, 1, 8'h00, 16'h038f}, '{0, 2, 8'h00, 16'h078f},
    '{0, 3, 8'h00, 16'h8f8f}, '{0, 0, 8'h00, 16'hcf8f}, '{1, 2, 8'h42, 16'h4b8f},
    '{2, 1, 8'h00, 16'h4b0d}, '{3, 1, 8'h51, 16'h4b8f}, '{3, 1, 8'h00, 16'h4bcf},
    '{4, 255, 8'h00, 16'h4bcf}, '{4, 0, 8'h00, 16'h0b8f}, '{2, 0, 8'h00, 16'h0b0e}};
  pps_port_status i_dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .host_wr,
    .host_rd, .host_addr, .host_wdata, .host_rdata, .host_rvalid, .host_stall_n);
  pps_host_model i_host (.ref_clk, .host_stall_n, .host_rvalid, .host_rdata, .host_wr,
    .host_rd, .host_addr, .host_wdata);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // outputs while reset is held: bus busy, no read data, no host answer, room for the host
  task automatic rst_vals();
    chk({31'h0, avs_waitrequest}, 32'h1);
    chk(avs_readdata, 32'h0);
    chk({31'h0, host_rvalid}, 32'h0);
    chk({31'h0, host_stall_n}, 32'h1);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic do_op(input pps_row_t r);
    if (r.op == 1 || r.op == 2) bus(1'b1, pps_pkg::OFF_FIFO_LVL, {22'h0, r.a[1:0], 8'h00});
    case (r.op)
      0: i_host.put(r.a[1:0], 8'h40 + r.a[7:0], 1);
      1: bus(1'b0, pps_pkg::OFF_IN_DATA, 32'h0);
      2: bus(1'b1, pps_pkg::OFF_OUT_DATA, {24'h0, 8'h50 + r.a[7:0]});
      3: i_host.get(r.a[1:0], hd);
      4: bus(1'b1, pps_pkg::OFF_STATUS, {4{r.a[7:0]}});
      default: ;
    endcase
    if (r.op == 1) chk({24'h0, rdat[7:0]}, {24'h0, r.dat});
    if (r.op == 3) chk({24'h0, hd}, {24'h0, r.dat});
    repeat (4) @(posedge ref_clk);
    bus(1'b0, pps_pkg::OFF_STATUS, 32'h0);
    chk(rdat, {16'h0, r.st});
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (16) @(posedge ref_clk);
    rst_vals();
    rst_n <= 1'b1;
    @(posedge ref_clk);
    do_op('{5, 0, 8'h00, 16'h008f});
    $display("reset values done");
    foreach (rows[i]) begin
      do_op(rows[i]);
      $display("row %0d done", i);
    end
    // overflowing bytes must not replace the held one
    i_host.put(2'd3, 8'h90, 40);
    do_op('{1, 3, 8'h43, 16'h430e});
    bus(1'b0, pps_pkg::OFF_FIFO_LVL, 32'h0);
    chk(rdat, {22'h0, 2'd3, 8'h00});
    chk({31'h0, host_stall_n}, 32'h1);
    bus(1'b0, 4'h9, 32'h0);
    chk(rdat, pps_pkg::RD_UNMAPPED);
    $display("burst and unmapped done");
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_vals();
    rst_n <= 1'b1;
    @(posedge ref_clk);
    do_op('{5, 0, 8'h00, 16'h008f});
    $display("second reset done");
    finish_test();
  end
endmodule

//--- verilog/pps_fifo.sv
// synchronous fifo with registered read data and valid/ready on both sides
`timescale 1ns/1ps
module pps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic  ref_clk,
  input wire logic  rst_n,
  pps_fifo_if.fifo  f,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic [WIDTH-1:0] dout_r;
  logic             dvalid_r;
  logic             push;
  logic             pop;
  logic             load;

  assign f.in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign push        = f.in_valid && f.in_ready;
  // output register refills whenever it is empty or being taken and the fifo holds data
  assign load        = (!dvalid_r || f.out_ready) && (cnt_r != '0);
  assign pop         = load;
  assign f.out_valid = dvalid_r;
  assign f.out_data  = dout_r;
  assign level       = cnt_r;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= f.in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_r   <= '0;
      dvalid_r <= 1'b0;
    end else if (load) begin
      dout_r   <= mem[rd_ptr_r];
      dvalid_r <= 1'b1;
    end else if (f.out_ready) begin
      dvalid_r <= 1'b0;
    end
  end
endmodule

//--- verilog/pps_port_status.sv
// parallel port buffered slave: byte buffers, status flags and register slave
//
// What this block does
// - host write into a full input buffer sets sticky input overflow until software clears
// - input buffer full flag set by host write, cleared by software read
// - all inputs full reads zero when any input buffer is empty
// - all outputs empty reads one only when every output buffer is empty
// - output buffer empty flag set by host read, cleared by software write
// - status bits 13-12 and 5-4 read zero and ignore writes
`timescale 1ns/1ps
module pps_port_status #(
  parameter int NBUF    = pps_pkg::NBUF,
  parameter int FIFO_D  = 32
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // avalon-mm slave
  input  wire logic [pps_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  // host side of the parallel port
  input  wire logic                      host_wr,
  input  wire logic                      host_rd,
  input  wire logic [1:0]                host_addr,
  input  wire logic [7:0]                host_wdata,
  output logic [7:0]                     host_rdata,
  output logic                           host_rvalid,
  output logic                           host_stall_n
);

  // ****************************************************************
  // buffers and flags
  // ****************************************************************
  logic [7:0]      in_buf_r  [NBUF];
  logic [7:0]      out_buf_r [NBUF];
  logic [NBUF-1:0] in_full_r;
  logic [NBUF-1:0] out_empty_r;
  logic            in_ovf_r;
  logic            out_unf_r;
  logic [31:0]     rdata_r;
  logic            waitreq_r;
  logic [7:0]      hrdata_r;
  logic            hrvalid_r;
  logic            stall_n_r;

  // ****************************************************************
  // host writes pass through the fifo so bursts are absorbed
  // ****************************************************************
  pps_fifo_if #(.W(10)) hw_if ();
  logic [$clog2(FIFO_D):0] fifo_level;

  pps_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .f       (hw_if),
    .level   (fifo_level)
  );

  assign hw_if.in_valid = host_wr;
  assign hw_if.in_data  = {host_addr, host_wdata};
  // the drain always accepts: a full buffer is an overflow, not a stall
  assign hw_if.out_ready = 1'b1;

  logic       drain;
  logic [1:0] d_idx;
  assign drain = hw_if.out_valid;
  assign d_idx = hw_if.out_data[9:8];

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic sel_status;
  logic sel_in;
  logic sel_out;
  logic acc;
  logic [1:0] sw_idx;
  assign acc        = (avs_read || avs_write) && waitreq_r;
  assign sel_status = avs_address == pps_pkg::OFF_STATUS;
  assign sel_in     = avs_address == pps_pkg::OFF_IN_DATA;
  assign sel_out    = avs_address == pps_pkg::OFF_OUT_DATA;
  // data accesses use the buffer index held in the index register
  logic [1:0] sel_idx_r;
  assign sw_idx = sel_idx_r;

  logic sw_in_rd;
  logic sw_out_wr;
  logic sw_stat_wr;
  assign sw_in_rd   = acc && avs_read && sel_in;
  assign sw_out_wr  = acc && avs_write && sel_out && avs_byteenable[0];
  assign sw_stat_wr = acc && avs_write && sel_status;

  // one wait cycle per access: waitrequest drops for one cycle after the request is taken;
  // kept as a flop so the bus never sees a decode glitch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= !acc;
    end
  end
  assign avs_waitrequest = waitreq_r;

  // buffer index register, written at the level offset with byte lane 1
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_idx_r <= 2'h0;
    end else if (acc && avs_write && avs_address == pps_pkg::OFF_FIFO_LVL
                 && avs_byteenable[pps_pkg::IDX_LO / 8]) begin
      sel_idx_r <= avs_writedata[pps_pkg::IDX_LO +: 2];
    end
  end

  // ****************************************************************
  // input buffers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (drain && !in_full_r[d_idx]) begin
      in_buf_r[d_idx] <= hw_if.out_data[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_full_r <= pps_pkg::RST_IN_FULL;
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        // a host fill in the same cycle wins over the software clear
        if (drain && d_idx == 2'(i) && !in_full_r[i]) begin
          in_full_r[i] <= 1'b1;
        end else if (sw_in_rd && sw_idx == 2'(i)) begin
          in_full_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ovf_r <= 1'b0;
    end else if (drain && in_full_r[d_idx]) begin
      in_ovf_r <= 1'b1;
    end else if (sw_stat_wr && avs_byteenable[pps_pkg::BIT_IN_OVERFLOW / 8]
                 && !avs_writedata[pps_pkg::BIT_IN_OVERFLOW]) begin
      in_ovf_r <= 1'b0;
    end
  end

  // ****************************************************************
  // output buffers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (sw_out_wr) begin
      out_buf_r[sw_idx] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_empty_r <= pps_pkg::RST_OUT_EMPTY;
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        if (sw_out_wr && sw_idx == 2'(i)) begin
          out_empty_r[i] <= 1'b0;
        end else if (host_rd && host_addr == 2'(i)) begin
          out_empty_r[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_unf_r <= 1'b0;
    end else if (host_rd && out_empty_r[host_addr]) begin
      out_unf_r <= 1'b1;
    end else if (sw_stat_wr && avs_byteenable[pps_pkg::BIT_OUT_UNDERFLOW / 8]
                 && !avs_writedata[pps_pkg::BIT_OUT_UNDERFLOW]) begin
      out_unf_r <= 1'b0;
    end
  end

  // host read answer, zero data when the buffer was empty
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r  <= 8'h00;
      hrvalid_r <= 1'b0;
    end else begin
      hrvalid_r <= host_rd;
      if (host_rd) begin
        hrdata_r <= out_empty_r[host_addr] ? 8'h00 : out_buf_r[host_addr];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_n_r <= 1'b1;
    end else begin
      stall_n_r <= hw_if.in_ready;
    end
  end

  assign host_rdata   = hrdata_r;
  assign host_rvalid  = hrvalid_r;
  assign host_stall_n = stall_n_r;

  // ****************************************************************
  // status word and read mux
  // ****************************************************************
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[pps_pkg::BIT_ALL_IN_FULL]   = &in_full_r;
    status[pps_pkg::BIT_IN_OVERFLOW]   = in_ovf_r;
    status[pps_pkg::BIT_IN_FULL_LO +: NBUF] = in_full_r;
    status[pps_pkg::BIT_ALL_OUT_EMPTY] = &out_empty_r;
    status[pps_pkg::BIT_OUT_UNDERFLOW] = out_unf_r;
    status[pps_pkg::BIT_OUT_EMPTY_LO +: NBUF] = out_empty_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= pps_pkg::RD_UNMAPPED;
    end else if (acc && avs_read) begin
      unique case (avs_address)
        pps_pkg::OFF_STATUS:   rdata_r <= {16'h0000, status};
        pps_pkg::OFF_IN_DATA:  rdata_r <= {24'h000000, in_buf_r[sw_idx]};
        pps_pkg::OFF_OUT_DATA: rdata_r <= {24'h000000, out_buf_r[sw_idx]};
        pps_pkg::OFF_FIFO_LVL: rdata_r <= {22'h0, sel_idx_r, 2'h0,
                                           6'(fifo_level)};
        default:               rdata_r <= pps_pkg::RD_UNMAPPED;
      endcase
    end
  end
  assign avs_readdata = rdata_r;

endmodule
